// ===== core/aux_in_ctrl.sv
// interlock, transient trigger and phase sync input control with apb registers
`timescale 1ns/1ns
`include "aux_in_cfg.svh"
module aux_in_ctrl
  import aux_in_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = `CLK_HZ / 1000000 * `TICK_US,
  parameter int unsigned COUNTDOWN_MS = `COUNTDOWN_MS,
  parameter int unsigned REF_PMIN     = (`CLK_HZ + `REF_FMAX_HZ - 1) / `REF_FMAX_HZ,
  parameter int unsigned REF_PMAX     = `CLK_HZ / `REF_FMIN_HZ
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        interlock_input,
  input  wire logic        transient_start_input,
  input  wire logic        sync_ttl_input,
  input  wire logic        line_ref_input,
  input  wire logic        transient_done,
  output logic             output_enable,
  output logic             interlock_fault,
  output logic             countdown_active,
  output logic             countdown_beep,
  output logic             transient_go,
  output logic             transient_running,
  output logic             transient_progress_zero,
  output logic             sync_locked,
  output disp_t            status_field,
  output phases_t          phase_out
);

  // reset tuning words for setpoint and range
  localparam logic [31:0] FREQ_RST_WORD  = 32'((64'(`FREQ_RST_HZ) << 32) / 64'(`CLK_HZ));
  localparam logic [31:0] RANGE_RST_WORD = 32'((64'(`RANGE_RST_HZ) << 32) / 64'(`CLK_HZ));
  localparam logic [11:0] PERIOD_MS      = 12'(`STATUS_PERIOD_MS);
  localparam logic [11:0] SHOW_MS        = 12'(`STATUS_SHOW_MS);
  localparam logic [15:0] CD_MS          = 16'(COUNTDOWN_MS);
  localparam logic [7:0]  BEEP_MS        = 8'(`BEEP_MS);
  localparam logic [21:0] PMIN           = 22'(REF_PMIN);
  localparam logic [21:0] PMAX           = 22'(REF_PMAX);

  // clamp a tuning word into setpoint plus or minus range
  function automatic logic [31:0] clamp_word(input logic [31:0] w, input logic [31:0] lo,
                                             input logic [31:0] hi);
    clamp_word = (w < lo) ? lo : ((w > hi) ? hi : w);
  endfunction

  // registers
  ctl_t        ctl_reg;                       // control word
  logic [31:0] freq_reg;                      // nominal_frequency_target tuning word
  logic [31:0] range_reg;                     // window half width, tuning word
  logic [3:0]  speed_reg;                     // loop gain shift
  logic [15:0] offset_reg;                    // reference_offset_setting
  logic [15:0] phb_reg;                       // phase B angle to A
  logic [15:0] phc_reg;                       // phase C angle to A
  logic [31:0] prdata_reg;                    // latched read data
  logic        pslverr_reg;                   // latched error answer

  // input synchronisers and edge detection
  logic [3:0]  meta_reg;                      // first stage, read only by second
  logic [3:0]  in_reg;                        // synchronised levels
  logic [3:0]  prev_reg;                      // previous levels
  logic [1:0]  pu_cnt_reg;                    // power-up settle count
  logic        pu_done_reg;                   // power-up event done

  // sequencers and timers
  en_st_t      en_st_reg;
  en_st_t      en_st_next;
  tr_st_t      tr_st_reg;
  tr_st_t      tr_st_next;
  logic [15:0] tick_reg;                      // divider to 1 ms enable
  logic [15:0] cd_ms_reg;                     // countdown elapsed ms
  logic [7:0]  beep_ms_reg;                   // beep half period count
  logic        beep_reg;
  logic [11:0] disp_ms_reg;                   // status rotation ms
  logic        go_reg;
  disp_t       disp_reg;

  // sync engine
  logic [31:0] acc_reg;                       // phase accumulator
  logic [31:0] inc_reg;                       // tuning word in use
  logic [21:0] per_reg;                       // cycles since last reference edge
  logic        ref_ok_reg;                    // reference period in range
  logic [2:0]  lock_cnt_reg;
  logic        locked_reg;
  phases_t     ph_reg;

  // apb decode
  wire         wr_acc   = psel & penable & pwrite;
  wire         setup    = psel & ~penable;
  wire         wr_ctrl  = wr_acc & (paddr == `A_CTRL);
  wire         wr_cmd   = wr_acc & (paddr == `A_CMD);
  wire         hit      = (paddr <= `A_INC) & (paddr[1:0] == 2'h0);
  wire         cmd_en   = wr_cmd & pwdata[`CMD_EN];
  wire         cmd_dis  = wr_cmd & pwdata[`CMD_DIS];
  wire         cmd_go   = wr_cmd & pwdata[`CMD_LAUNCH];
  wire         cmd_san  = wr_cmd & pwdata[`CMD_SANITIZE];
  wire         cmd_clr  = wr_cmd & pwdata[`CMD_CLR];

  // edges of synchronised inputs
  wire  [3:0]  rise     = in_reg & ~prev_reg;
  wire  [3:0]  fall     = ~in_reg & prev_reg;
  wire         contact  = in_reg[0];
  wire         pu_pulse = (pu_cnt_reg == 2'h3) & ~pu_done_reg;
  wire         ms_tick  = (tick_reg == 16'(TICK_CYCLES - 1));

  // interlock decisions
  wire         is_inh   = (ctl_reg.mode == IL_INHIBIT);
  wire         is_rem   = (ctl_reg.mode == IL_REMOTE);
  wire         permit   = ~is_inh | contact;
  wire         pu_on    = ctl_reg.auto_en & pu_pulse & contact;
  wire         rem_on   = is_rem & (rise[0] | pu_on);
  wire         rem_off  = is_rem & fall[0];
  wire         cd_done  = ms_tick & (cd_ms_reg == CD_MS - 16'h1);

  // output enable sequencer
  always_comb
  begin
    en_st_next = en_st_reg;
    unique case (en_st_reg)
      ST_OFF:
      begin
        if (rem_on)
          en_st_next = ST_COUNT;
        else if (cmd_en & permit)
          en_st_next = ST_ON;
      end
      ST_COUNT:
      begin
        if (cmd_dis | rem_off | ~is_rem)
          en_st_next = ST_OFF;
        else if (cd_done)
          en_st_next = ST_ON;
      end
      ST_ON:
      begin
        if (is_inh & ~contact)
          en_st_next = ST_FAULT;
        else if (cmd_dis | rem_off)
          en_st_next = ST_OFF;
      end
      ST_FAULT:
      begin
        if (cmd_clr)
          en_st_next = ST_OFF;
      end
    endcase
  end

  // transient launch sequencer
  always_comb
  begin
    tr_st_next = tr_st_reg;
    unique case (tr_st_reg)
      TR_IDLE:
      begin
        if (cmd_go)
          tr_st_next = ctl_reg.trig_mode ? TR_WAIT : TR_RUN;
      end
      TR_WAIT:
      begin
        if (rise[1])
          tr_st_next = TR_RUN;
      end
      TR_RUN:
      begin
        if (transient_done)
          tr_st_next = TR_IDLE;
      end
      default:
        tr_st_next = TR_IDLE;
    endcase
  end

  // sync engine decode
  wire         ref_rise = ctl_reg.sync_line ? rise[3] : rise[2];
  wire         ref_lost = (per_reg > PMAX);
  wire         per_ok   = (per_reg >= PMIN) & (per_reg <= PMAX);
  wire  [15:0] err      = offset_reg - acc_reg[31:16];
  wire  [15:0] err_abs  = err[15] ? 16'(-err) : err;
  wire  [31:0] err_ext  = {{16{err[15]}}, err};
  wire  [31:0] f_adj    = 32'($signed(err_ext) >>> speed_reg);
  wire  [31:0] p_kick   = 32'($signed({err, 16'h0000}) >>> speed_reg);
  wire         track    = ctl_reg.sync_en & ref_rise & per_ok;
  wire  [31:0] w_lo     = freq_reg - range_reg;
  wire  [31:0] w_hi     = freq_reg + range_reg;
  wire  [31:0] inc_raw  = track ? (inc_reg + f_adj) : inc_reg;
  wire  [31:0] inc_sel  = ctl_reg.sync_en ? inc_raw : freq_reg;
  wire  [31:0] inc_next = clamp_word(inc_sel, w_lo, w_hi);
  wire         in_win   = (clamp_word(inc_raw, w_lo, w_hi) == inc_raw);
  wire  [31:0] acc_next = acc_reg + inc_reg + (track ? p_kick : 32'h0);
  wire         good     = track & (err_abs < `LOCK_ERR) & in_win;

  // status field selection
  wire         show_syn = locked_reg & (disp_ms_reg < SHOW_MS);
  wire         unsyn    = ctl_reg.sync_en & ~locked_reg;
  wire  disp_t base     = (en_st_reg == ST_FAULT) ? DISP_FAULT :
                          ((en_st_reg == ST_ON) ? DISP_ENABLED : DISP_READY);
  wire  disp_t disp_nx  = unsyn ? DISP_UNSYNCED : (show_syn ? DISP_SYNCED : base);

  // read mux
  wire  [31:0] st_word  = {24'h0, contact, (en_st_reg == ST_COUNT), ref_ok_reg,
                           (tr_st_reg == TR_RUN), (tr_st_reg == TR_WAIT), locked_reg,
                           (en_st_reg == ST_FAULT), (en_st_reg == ST_ON)};
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0;
    unique case (paddr)
      `A_CTRL:   rdata = {26'h0, ctl_reg};
      `A_STATUS: rdata = st_word;
      `A_FREQ:   rdata = freq_reg;
      `A_RANGE:  rdata = range_reg;
      `A_SPEED:  rdata = {28'h0, speed_reg};
      `A_OFFSET: rdata = {16'h0, offset_reg};
      `A_PHB:    rdata = {16'h0, phb_reg};
      `A_PHC:    rdata = {16'h0, phc_reg};
      `A_INC:    rdata = inc_reg;
      default:   rdata = 32'h0;
    endcase
  end

  // apb answer latched in the setup cycle, zero wait states
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      prdata_reg  <= (pwrite | ~hit) ? 32'h0 : rdata;
      pslverr_reg <= ~hit;
    end
  end

  // configuration registers, sanitize overrides remote settings
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_reg    <= '{sync_line: 1'b0, sync_en: 1'b0, trig_mode: 1'b0,
                      auto_en: `AUTO_RST, mode: IL_OFF};
      freq_reg   <= FREQ_RST_WORD;
      range_reg  <= RANGE_RST_WORD;
      speed_reg  <= `SPEED_RST;
      offset_reg <= 16'h0;
      phb_reg    <= 16'h0;
      phc_reg    <= 16'h0;
    end
    else
    begin
      if (cmd_san)
      begin
        ctl_reg.auto_en <= 1'b1;
        if (is_rem)
          ctl_reg.mode <= IL_OFF;
      end
      else if (wr_ctrl)
        ctl_reg <= ctl_t'(pwdata[5:0]);
      if (wr_acc & (paddr == `A_FREQ))
        freq_reg <= pwdata;
      if (wr_acc & (paddr == `A_RANGE))
        range_reg <= pwdata;
      if (wr_acc & (paddr == `A_SPEED))
        speed_reg <= pwdata[3:0];
      if (wr_acc & (paddr == `A_OFFSET))
        offset_reg <= pwdata[15:0];
      if (wr_acc & (paddr == `A_PHB))
        phb_reg <= pwdata[15:0];
      if (wr_acc & (paddr == `A_PHC))
        phc_reg <= pwdata[15:0];
    end
  end

  // two-flop synchronisers and power-up settle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg    <= 4'h0;
      in_reg      <= 4'h0;
      prev_reg    <= 4'h0;
      pu_cnt_reg  <= 2'h0;
      pu_done_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= {line_ref_input, sync_ttl_input, transient_start_input,
                   interlock_input};
      in_reg   <= meta_reg;
      prev_reg <= in_reg;
      if (pu_cnt_reg != 2'h3)
        pu_cnt_reg <= pu_cnt_reg + 2'h1;
      if (pu_pulse)
        pu_done_reg <= 1'b1;
    end
  end

  // sequencer state and millisecond timers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_st_reg   <= ST_OFF;
      tr_st_reg   <= TR_IDLE;
      go_reg      <= 1'b0;
      tick_reg    <= 16'h0;
      cd_ms_reg   <= 16'h0;
      beep_ms_reg <= 8'h0;
      beep_reg    <= 1'b0;
      disp_ms_reg <= 12'h0;
      disp_reg    <= DISP_READY;
    end
    else
    begin
      en_st_reg <= en_st_next;
      tr_st_reg <= tr_st_next;
      go_reg    <= (tr_st_next == TR_RUN) & (tr_st_reg != TR_RUN);
      tick_reg  <= ms_tick ? 16'h0 : tick_reg + 16'h1;
      disp_reg  <= disp_nx;
      // countdown with beeping while waiting to enable
      if (en_st_reg != ST_COUNT)
      begin
        cd_ms_reg   <= 16'h0;
        beep_ms_reg <= 8'h0;
        beep_reg    <= 1'b0;
      end
      else if (ms_tick)
      begin
        cd_ms_reg <= cd_ms_reg + 16'h1;
        if (beep_ms_reg == BEEP_MS - 8'h1)
        begin
          beep_ms_reg <= 8'h0;
          beep_reg    <= ~beep_reg;
        end
        else
          beep_ms_reg <= beep_ms_reg + 8'h1;
      end
      // three second rotation of the status field
      if (ms_tick)
        disp_ms_reg <= (disp_ms_reg == PERIOD_MS - 12'h1) ? 12'h0 : disp_ms_reg + 12'h1;
    end
  end

  // phase lock engine and waveform phase generation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg      <= 32'h0;
      inc_reg      <= FREQ_RST_WORD;
      per_reg      <= 22'h0;
      ref_ok_reg   <= 1'b0;
      lock_cnt_reg <= 3'h0;
      locked_reg   <= 1'b0;
      ph_reg       <= '0;
    end
    else
    begin
      acc_reg <= acc_next;
      inc_reg <= inc_next;
      // reference period measurement, saturates once lost
      if (ref_rise)
      begin
        per_reg    <= 22'h0;
        ref_ok_reg <= per_ok;
      end
      else if (!ref_lost)
        per_reg <= per_reg + 22'h1;
      else
        ref_ok_reg <= 1'b0;
      // lock qualification over consecutive reference edges
      if (!ctl_reg.sync_en || ref_lost)
      begin
        lock_cnt_reg <= 3'h0;
        locked_reg   <= 1'b0;
      end
      else if (ref_rise)
      begin
        if (!good)
        begin
          lock_cnt_reg <= 3'h0;
          locked_reg   <= 1'b0;
        end
        else if (lock_cnt_reg == 3'(`LOCK_EDGES - 1))
          locked_reg <= 1'b1;
        else
          lock_cnt_reg <= lock_cnt_reg + 3'h1;
      end
      ph_reg.a <= acc_next[31:16];
      ph_reg.b <= acc_next[31:16] + phb_reg;
      ph_reg.c <= acc_next[31:16] + phc_reg;
    end
  end

  // outputs
  assign prdata                  = prdata_reg;
  assign pready                  = 1'b1;
  assign pslverr                 = pslverr_reg;
  assign output_enable           = (en_st_reg == ST_ON);
  assign interlock_fault         = (en_st_reg == ST_FAULT);
  assign countdown_active        = (en_st_reg == ST_COUNT);
  assign countdown_beep          = beep_reg;
  assign transient_go            = go_reg;
  assign transient_running       = (tr_st_reg != TR_IDLE);
  assign transient_progress_zero = (tr_st_reg == TR_WAIT);
  assign sync_locked             = locked_reg;
  assign status_field            = disp_reg;
  assign phase_out               = ph_reg;

endmodule // aux_in_ctrl

// ===== core/aux_in_cfg.svh
// constants for the dedicated interlock, trigger and sync input block
`ifndef AUX_IN_CFG_SVH
`define AUX_IN_CFG_SVH
`define CLK_HZ            50000000
// register byte offsets
`define A_CTRL            8'h00
`define A_CMD             8'h04
`define A_STATUS          8'h08
`define A_FREQ            8'h0C
`define A_RANGE           8'h10
`define A_SPEED           8'h14
`define A_OFFSET          8'h18
`define A_PHB             8'h1C
`define A_PHC             8'h20
`define A_INC             8'h24
// command bit positions
`define CMD_EN            0
`define CMD_DIS           1
`define CMD_LAUNCH        2
`define CMD_SANITIZE      3
`define CMD_CLR           4
// reset values
`define AUTO_RST          1'b1
`define FREQ_RST_HZ       60
`define RANGE_RST_HZ      10
`define SPEED_RST         4'h8
// times and limits
`define TICK_US           1000
`define STATUS_PERIOD_MS  3000
`define STATUS_SHOW_MS    1000
`define COUNTDOWN_MS      5000
`define BEEP_MS           250
`define REF_FMIN_HZ       15
`define REF_FMAX_HZ       1200
`define LOCK_EDGES        4
`define LOCK_ERR          16'h0800
`endif

// ===== core/aux_in_pkg.sv
// types for the dedicated interlock, trigger and sync input block
package aux_in_pkg;
  // interlock modes
  typedef enum logic [1:0] {IL_OFF = 2'h0, IL_INHIBIT = 2'h1, IL_REMOTE = 2'h2} il_mode_t;
  // output enable sequencer states, gray along off-count-on-fault
  typedef enum logic [1:0] {ST_OFF = 2'h0, ST_COUNT = 2'h1, ST_ON = 2'h3, ST_FAULT = 2'h2} en_st_t;
  // transient launch states
  typedef enum logic [1:0] {TR_IDLE = 2'h0, TR_WAIT = 2'h1, TR_RUN = 2'h3} tr_st_t;
  // status field shown on panel
  typedef enum logic [2:0] {DISP_READY = 3'h0, DISP_ENABLED = 3'h1, DISP_FAULT = 3'h2,
                            DISP_SYNCED = 3'h3, DISP_UNSYNCED = 3'h4} disp_t;
  // control word bundle
  typedef struct packed {
    logic     sync_line;   // 1 = line reference, 0 = ttl input
    logic     sync_en;     // sync engine active
    logic     trig_mode;   // transient waits for trigger edge
    logic     auto_en;     // power-up enable policy
    il_mode_t mode;        // interlock mode
  } ctl_t;
  // three phase angles out of the generator
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } phases_t;
endpackage

// ===== verification/aux_in_ctrl_asserts.sv
// concurrent checks on the ports of the interlock, trigger and sync block
`timescale 1ns/1ns
module aux_in_ctrl_asserts
  import aux_in_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        output_enable,
  input wire logic        interlock_fault,
  input wire logic        countdown_active,
  input wire logic        countdown_beep,
  input wire logic        transient_go,
  input wire logic        transient_running,
  input wire logic        transient_progress_zero,
  input wire logic        sync_locked,
  input wire disp_t       status_field
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_fault_no_out: assert property (interlock_fault |-> !output_enable)
    else $error("output on while in fault");
  a_fault_cause: assert property ($rose(interlock_fault) |-> $past(output_enable))
    else $error("fault without enabled output");
  a_go_single: assert property (transient_go |=> !transient_go)
    else $error("start pulse longer than one cycle");
  a_wait_running: assert property (transient_progress_zero |-> transient_running)
    else $error("waiting transient not shown running");
  a_wait_no_go: assert property (transient_progress_zero |-> !transient_go)
    else $error("transient started while waiting");
  a_synced_locked: assert property (status_field == DISP_SYNCED |-> sync_locked || $past(sync_locked))
    else $error("synced shown while unlocked");
  a_count_no_out: assert property (countdown_active |-> !output_enable)
    else $error("output on during countdown");
  a_beep_quiet: assert property (!countdown_active && !$past(countdown_active) |-> !countdown_beep)
    else $error("beep outside countdown");
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h24 |=> pready ##0 pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  c_go: cover property (transient_go);
  c_locked: cover property ($rose(sync_locked));
  c_fault: cover property ($rose(interlock_fault));
endmodule // aux_in_ctrl_asserts

bind aux_in_ctrl aux_in_ctrl_asserts aux_in_ctrl_asserts_inst (.clk, .rst_n, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .output_enable, .interlock_fault, .countdown_active,
  .countdown_beep, .transient_go, .transient_running, .transient_progress_zero, .sync_locked,
  .status_field);

// ===== verification/aux_src.sv
// external contacts, trigger source and sync reference sources
`timescale 1ns/1ns
module aux_src (
  input  wire logic        clk,
  input  wire logic        contact,
  input  wire logic        trig,
  input  wire logic [15:0] ref_period,
  output logic             interlock_input,
  output logic             transient_start_input,
  output logic             sync_ttl_input,
  output logic             line_ref_input
);
  logic [15:0] cnt_reg;  // position inside one reference period
  // contacts and trigger are plain levels from outside
  assign interlock_input       = contact;
  assign transient_start_input = trig;
  // square reference, held low when the source is absent
  always_ff @(posedge clk)
  begin
    cnt_reg <= (ref_period == 16'h0 || cnt_reg + 16'h1 >= ref_period) ? 16'h0 : cnt_reg + 16'h1;
  end
  assign sync_ttl_input = (ref_period != 16'h0) && (cnt_reg < ref_period / 2);
  assign line_ref_input = sync_ttl_input;
endmodule // aux_src

// ===== verification/testbench.sv
// self-checking bench for the interlock, trigger and sync block
`timescale 1ns/1ns
`include "aux_in_cfg.svh"
module testbench;
  import aux_in_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic        contact, trig, il_pin, tt_pin, ttl_pin, line_pin, transient_done;
  logic        output_enable, interlock_fault, countdown_active, countdown_beep;
  logic        transient_go, transient_running, transient_progress_zero, sync_locked;
  logic [15:0] ref_period;
  disp_t       status_field;
  phases_t     phase_out;
  int          miscompares, n_tests;
  logic [31:0] mem [0:9];  // model of the stored registers
  aux_in_ctrl #(.TICK_CYCLES(10), .COUNTDOWN_MS(3), .REF_PMIN(20), .REF_PMAX(2000))
    aux_in_ctrl_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .interlock_input(il_pin), .transient_start_input(tt_pin),
    .sync_ttl_input(ttl_pin), .line_ref_input(line_pin), .transient_done, .output_enable,
    .interlock_fault, .countdown_active, .countdown_beep, .transient_go, .transient_running,
    .transient_progress_zero, .sync_locked, .status_field, .phase_out);
  aux_src aux_src_inst (.clk, .contact, .trig, .ref_period, .interlock_input(il_pin),
    .transient_start_input(tt_pin), .sync_ttl_input(ttl_pin), .line_ref_input(line_pin));
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // verdict and end of run
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // compare one value with its expectation
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  // one apb transfer, answer taken at the edge where pready is high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20)
    begin
      chk(1'b0, 1'b1, "no pready");
      report_and_stop();
    end
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // write and keep the model in step
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      `A_CTRL: mem[0] = d & 32'h3F;
      `A_FREQ, `A_RANGE: mem[a >> 2] = d;
      `A_SPEED: mem[5] = d & 32'hF;
      `A_OFFSET, `A_PHB, `A_PHC: mem[a >> 2] = d & 32'hFFFF;
      `A_CMD: if (d[`CMD_SANITIZE]) mem[0] = (mem[0] | 32'h4) & ((mem[0][1:0] == 2'h2) ? ~32'h3 : ~32'h0);
      default: ;
    endcase
  endtask
  // read and compare with the model
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(q, mem[a >> 2], "register read");
  endtask
  // choose one watched output
  function logic sig(input int k);
    case (k)
      0: return output_enable;
      1: return interlock_fault;
      2: return countdown_active;
      3: return transient_go;
      4: return transient_running;
      5: return transient_progress_zero;
      6: return sync_locked;
      default: return status_field == DISP_SYNCED;
    endcase
  endfunction
  // bounded wait for an output level, sampled at the falling edge
  task wait_sig(input int k, input logic v, input int n);
    int i;
    for (i = 0; i < n && sig(k) !== v; i++) @(negedge clk);
    chk(sig(k), v, "wait for output");
    if (sig(k) !== v) report_and_stop();
  endtask
  // next value of the stimulus shift register
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmd(input int b);
    wr(`A_CMD, 32'h1 << b);
  endtask
  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, contact, trig, transient_done} = '0;
    ref_period = 16'h0; rst_n = 1'b0; seed = 32'hF2278461;
    mem = '{32'h4, 32'h0, 32'h0, 32'h00001421, 32'h35A, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (mem[i]) if (i != 1 && i < 9) rd(8'(i * 4));
    foreach (mem[i]) if (i != 1 && i < 9) rd(8'(i * 4));
    apb(1'b0, 8'h28, 32'h0); chk(q, 32'h0, "unmapped data");
    chk(err, 1'b1, "unmapped error");
    apb(1'b0, 8'h02, 32'h0); chk(err, 1'b1, "misaligned");
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(`A_OFFSET, seed); rd(`A_OFFSET); wr(`A_PHC, ~seed); rd(`A_PHC);
    end
    wr(`A_CTRL, 32'h0); cmd(`CMD_EN); wait_sig(0, 1'b1, 5);
    cmd(`CMD_DIS); wait_sig(0, 1'b0, 5);
    wr(`A_CTRL, 32'h1); cmd(`CMD_EN); repeat (5) @(negedge clk); chk(output_enable, 1'b0, "refused");
    @(posedge clk) contact <= 1'b1;
    repeat (5) @(posedge clk);
    cmd(`CMD_EN); wait_sig(0, 1'b1, 5);
    @(posedge clk) contact <= 1'b0;
    wait_sig(1, 1'b1, 10);
    cmd(`CMD_DIS); chk(interlock_fault, 1'b1, "fault held");
    cmd(`CMD_CLR); wait_sig(1, 1'b0, 5);
    wr(`A_CTRL, 32'h2); @(posedge clk) contact <= 1'b1;
    wait_sig(2, 1'b1, 10); chk(output_enable, 1'b0, "countdown first");
    wait_sig(0, 1'b1, 60);
    @(posedge clk) contact <= 1'b0;
    wait_sig(0, 1'b0, 10);
    cmd(`CMD_SANITIZE); rd(`A_CTRL);
    wr(`A_CTRL, 32'hC); cmd(`CMD_LAUNCH); wait_sig(5, 1'b1, 5);
    repeat (10) @(negedge clk); chk({transient_running, transient_progress_zero}, 2'h3, "held");
    @(posedge clk) trig <= 1'b1;
    wait_sig(3, 1'b1, 10); chk(transient_progress_zero, 1'b0, "started");
    @(posedge clk) transient_done <= 1'b1;
    @(posedge clk) transient_done <= 1'b0;
    wait_sig(4, 1'b0, 5);
    @(posedge clk) trig <= 1'b0;
    wr(`A_CTRL, 32'h4); cmd(`CMD_LAUNCH); wait_sig(3, 1'b1, 5);
    @(posedge clk) transient_done <= 1'b1;
    @(posedge clk) transient_done <= 1'b0;
    wr(`A_FREQ, 32'h00418937);
    wr(`A_SPEED, 32'h1);
    wr(`A_CTRL, 32'h14); @(posedge clk) ref_period <= 16'd1000;
    repeat (5) @(negedge clk); chk(status_field, DISP_UNSYNCED, "unsynced");
    wait_sig(6, 1'b1, 20000);
    apb(1'b0, `A_STATUS, 32'h0); chk(q[2], 1'b1, "lock bit");
    chk({16'h0, 16'(phase_out.c - phase_out.a)}, mem[8], "phase c angle");
    apb(1'b0, `A_INC, 32'h0); chk(q >= 32'h004185DD && q <= 32'h00418C91, 1'b1, "clamp");
    wait_sig(7, 1'b1, 31000); chk(output_enable, 1'b0, "kept off");
    @(posedge clk) ref_period <= 16'h0;
    wait_sig(6, 1'b0, 3000);
    report_and_stop();
  end
endmodule // testbench
